/* File: verilog/udi_pkg.sv */
package udi_pkg;

   // Register bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register offsets
   localparam logic [7:0] OFS_MODE = 8'h0C;
   localparam logic [7:0] OFS_ICFG = 8'h10;
   localparam logic [7:0] OFS_USB_EN = 8'h14;
   localparam logic [7:0] OFS_USB_STAT = 8'h18;
   localparam logic [7:0] OFS_USB_CLR = 8'h1C;
   localparam logic [7:0] OFS_DMA_EN = 8'h20;
   localparam logic [7:0] OFS_DMA_STAT = 8'h24;
   localparam logic [7:0] OFS_DMA_CLR = 8'h28;

   // Register widths
   localparam int MODE_W = 16;
   localparam int ICFG_W = 8;

   // Field positions in device_mode_control
   localparam int GLINT_BIT = 3;

   // Field positions in irq_signal_config
   localparam int STYLE_BIT = 0;
   localparam int POL_BIT = 1;
   localparam int CTRL_MODE_LSB = 2;
   localparam int IN_MODE_LSB = 4;
   localparam int OUT_MODE_LSB = 6;

   // Reset values: level signaling, active low, global enable off
   localparam logic [15:0] MODE_RST = 16'h0000;
   localparam logic [7:0] ICFG_RST = 8'h00;
   localparam logic [31:0] EN_RST = 32'h0000_0000;

   // Pulse timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int PULSE_NS = 60;
   localparam int PULSE_CYC_RAW = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_CYC = (PULSE_CYC_RAW < 1) ? 1 : PULSE_CYC_RAW;
   localparam int PULSE_CNT_W = 4;

   typedef enum logic {
      UDI_IDLE,
      UDI_PULSING
   } udi_pulse_state_t;

endpackage

/* File: verilog/udi_pulse_if.sv */
`timescale 1ns/10ps
interface udi_pulse_if;
   logic trigger;
   logic pulse_on;

   modport gen (
      input trigger,
      output pulse_on
   );

   modport ctl (
      output trigger,
      input pulse_on
   );
endinterface

/* File: verilog/udi_pulse_gen.sv */
`timescale 1ns/10ps
module udi_pulse_gen #(
   parameter int CYC = udi_pkg::PULSE_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   udi_pulse_if.gen pif
);

   udi_pkg::udi_pulse_state_t state;
   udi_pkg::udi_pulse_state_t next_state;
   logic [udi_pkg::PULSE_CNT_W-1:0] cnt;
   logic [udi_pkg::PULSE_CNT_W-1:0] next_cnt;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      case (state)
         udi_pkg::UDI_IDLE: begin
            if (pif.trigger) begin
               next_state = udi_pkg::UDI_PULSING;
               next_cnt = udi_pkg::PULSE_CNT_W'(CYC - 1);
            end
         end
         udi_pkg::UDI_PULSING: begin
            if (cnt == '0) begin
               next_state = udi_pkg::UDI_IDLE;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         default: begin
            next_state = udi_pkg::UDI_IDLE;
            next_cnt = '0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= udi_pkg::UDI_IDLE;
         cnt <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   assign pif.pulse_on = (state == udi_pkg::UDI_PULSING);

   property p_pulse_start;
      @(posedge clk) disable iff (!rst_n)
      (state == udi_pkg::UDI_IDLE && pif.trigger) |=> pif.pulse_on;
   endproperty
   a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start");

endmodule

/* File: verilog/udi_irq.sv */
// Overview of operation
// - Software selects pin polarity and level or pulse style in signal config.
// - Global enable bit in mode control masks the interrupt pin.
// - After reset the pin is active low with level signaling.
// - Pulse style emits one one-cycle (100 ns) pulse when combined request rises.
// - USB events and DMA events each set a sticky status bit.
// - A status bit counts only when its matching enable bit is set.
// - Three 2-bit mode fields for control, IN and OUT pipes.
// - With global enable off, events still log and a pin that is idle stays idle.
// - Level style: enabling globally with pending request asserts pin at once.
// - Level style: clearing global enable alone does not release the pin.
// - Pin releases when all pending status bits are cleared by software.
`timescale 1ns/10ps
module udi_irq #(
   parameter int N_USB = 32,
   parameter int N_DMA = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [udi_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [udi_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [udi_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [N_USB-1:0] usb_event,
   input wire logic [N_DMA-1:0] dma_event,
   output logic irq_pin,
   output logic [1:0] control_pipe_irq_mode,
   output logic [1:0] in_pipe_irq_mode,
   output logic [1:0] out_pipe_irq_mode
);

   // Set beats clear so an event in the clearing cycle survives
   function automatic logic [31:0] w1c(input logic [31:0] stat, input logic [31:0] clr,
                                       input logic [31:0] evt);
      return (stat & ~clr) | evt;
   endfunction

   function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
                                   input logic [7:0] ofs);
      return wr && (addr == ofs);
   endfunction

   // Register state
   logic [udi_pkg::MODE_W-1:0] mode;
   logic [udi_pkg::MODE_W-1:0] next_mode;
   logic [udi_pkg::ICFG_W-1:0] icfg;
   logic [udi_pkg::ICFG_W-1:0] next_icfg;
   logic [N_USB-1:0] usb_en;
   logic [N_USB-1:0] next_usb_en;
   logic [N_DMA-1:0] dma_en;
   logic [N_DMA-1:0] next_dma_en;
   logic [N_USB-1:0] usb_stat;
   logic [N_USB-1:0] next_usb_stat;
   logic [N_DMA-1:0] dma_stat;
   logic [N_DMA-1:0] next_dma_stat;
   logic [udi_pkg::DATA_W-1:0] next_rdata;
   logic [31:0] usb_stat_w;
   logic [31:0] dma_stat_w;

   // Interrupt output state
   logic irq_active;
   logic next_irq_active;
   logic req_prev;
   logic next_req_prev;
   logic next_irq_pin;

   logic global_en;
   logic pulse_style;
   logic pol_high;
   logic req_any;
   logic req_gated;
   logic pin_on_next;

   udi_pulse_if pif ();

   udi_pulse_gen #(
      .CYC(udi_pkg::PULSE_CYC)
   ) u_pulse (
      .clk(clk),
      .rst_n(rst_n),
      .pif(pif)
   );

   assign global_en = mode[udi_pkg::GLINT_BIT];
   assign pulse_style = icfg[udi_pkg::STYLE_BIT];
   assign pol_high = icfg[udi_pkg::POL_BIT];

   assign req_any = (|(usb_stat & usb_en)) | (|(dma_stat & dma_en));
   assign req_gated = req_any & global_en;

   assign pif.trigger = pulse_style & req_gated & ~req_prev;

   // Register writes and status logging
   always_comb begin
      next_mode = mode;
      next_icfg = icfg;
      next_usb_en = usb_en;
      next_dma_en = dma_en;
      if (wr_hit(reg_wr, reg_addr, udi_pkg::OFS_MODE)) begin
         next_mode = reg_wdata[udi_pkg::MODE_W-1:0];
      end
      if (wr_hit(reg_wr, reg_addr, udi_pkg::OFS_ICFG)) begin
         next_icfg = reg_wdata[udi_pkg::ICFG_W-1:0];
      end
      if (wr_hit(reg_wr, reg_addr, udi_pkg::OFS_USB_EN)) begin
         next_usb_en = reg_wdata[N_USB-1:0];
      end
      if (wr_hit(reg_wr, reg_addr, udi_pkg::OFS_DMA_EN)) begin
         next_dma_en = reg_wdata[N_DMA-1:0];
      end
      usb_stat_w = w1c(32'(usb_stat),
                       wr_hit(reg_wr, reg_addr, udi_pkg::OFS_USB_CLR) ? reg_wdata : 32'h0,
                       32'(usb_event));
      dma_stat_w = w1c(32'(dma_stat),
                       wr_hit(reg_wr, reg_addr, udi_pkg::OFS_DMA_CLR) ? reg_wdata : 32'h0,
                       32'(dma_event));
      next_usb_stat = usb_stat_w[N_USB-1:0];
      next_dma_stat = dma_stat_w[N_DMA-1:0];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= udi_pkg::MODE_RST;
         icfg <= udi_pkg::ICFG_RST;
         usb_en <= udi_pkg::EN_RST[N_USB-1:0];
         dma_en <= udi_pkg::EN_RST[N_DMA-1:0];
         usb_stat <= '0;
         dma_stat <= '0;
      end else begin
         mode <= next_mode;
         icfg <= next_icfg;
         usb_en <= next_usb_en;
         dma_en <= next_dma_en;
         usb_stat <= next_usb_stat;
         dma_stat <= next_dma_stat;
      end
   end

   // Read data, one cycle after the strobe; clear registers read as zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (reg_rd) begin
         case (reg_addr)
            udi_pkg::OFS_MODE: next_rdata = 32'(mode);
            udi_pkg::OFS_ICFG: next_rdata = 32'(icfg);
            udi_pkg::OFS_USB_EN: next_rdata = 32'(usb_en);
            udi_pkg::OFS_USB_STAT: next_rdata = 32'(usb_stat);
            udi_pkg::OFS_DMA_EN: next_rdata = 32'(dma_en);
            udi_pkg::OFS_DMA_STAT: next_rdata = 32'(dma_stat);
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // Pin drive
   always_comb begin
      next_irq_active = req_any & (irq_active | global_en);
      next_req_prev = req_gated;
      pin_on_next = pulse_style ? pif.pulse_on : next_irq_active;
      next_irq_pin = pol_high ? pin_on_next : ~pin_on_next;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_active <= 1'b0;
         req_prev <= 1'b0;
         irq_pin <= 1'b1;
      end else begin
         irq_active <= next_irq_active;
         req_prev <= next_req_prev;
         irq_pin <= next_irq_pin;
      end
   end

   assign control_pipe_irq_mode = icfg[udi_pkg::CTRL_MODE_LSB +: 2];
   assign in_pipe_irq_mode = icfg[udi_pkg::IN_MODE_LSB +: 2];
   assign out_pipe_irq_mode = icfg[udi_pkg::OUT_MODE_LSB +: 2];

   // Assertion helpers
   logic pin_on;
   logic first_cyc;
   logic pol_prev;

   // Pin lags a polarity write by one cycle
   assign pin_on = (irq_pin == pol_prev);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         first_cyc <= 1'b1;
         pol_prev <= udi_pkg::ICFG_RST[udi_pkg::POL_BIT];
      end else begin
         first_cyc <= 1'b0;
         pol_prev <= pol_high;
      end
   end

   property p_reset_cfg;
      @(posedge clk) disable iff (!rst_n)
      first_cyc |-> (irq_pin && !pulse_style && !pol_high && !global_en);
   endproperty
   a_reset_cfg: assert property (p_reset_cfg) else $error("reset config wrong");

   property p_usb_log;
      @(posedge clk) disable iff (!rst_n)
      (usb_event != '0) |=> ((usb_stat & $past(usb_event)) == $past(usb_event));
   endproperty
   a_usb_log: assert property (p_usb_log) else $error("usb event not logged");

   property p_dma_log;
      @(posedge clk) disable iff (!rst_n)
      (dma_event != '0) |=> ((dma_stat & $past(dma_event)) == $past(dma_event));
   endproperty
   a_dma_log: assert property (p_dma_log) else $error("dma event not logged");

   property p_usb_clear;
      @(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == udi_pkg::OFS_USB_CLR && usb_event == '0)
      |=> (usb_stat == ($past(usb_stat) & ~$past(reg_wdata[N_USB-1:0])));
   endproperty
   a_usb_clear: assert property (p_usb_clear) else $error("usb clear wrong");

   property p_masked_idle;
      @(posedge clk) disable iff (!rst_n)
      (!pulse_style && !irq_active && !global_en) |=> !pin_on;
   endproperty
   a_masked_idle: assert property (p_masked_idle) else $error("pin on while masked");

   property p_enable_asserts;
      @(posedge clk) disable iff (!rst_n)
      (!pulse_style && global_en && req_any) |=> pin_on;
   endproperty
   a_enable_asserts: assert property (p_enable_asserts) else $error("pin not asserted");

   property p_disable_holds;
      @(posedge clk) disable iff (!rst_n)
      (!pulse_style && irq_active && req_any && !global_en) |=> pin_on;
   endproperty
   a_disable_holds: assert property (p_disable_holds) else $error("pin dropped");

   property p_release;
      @(posedge clk) disable iff (!rst_n)
      (!pulse_style && !req_any) |=> !pin_on;
   endproperty
   a_release: assert property (p_release) else $error("pin not released");

   property p_unmasked_only;
      @(posedge clk) disable iff (!rst_n)
      (!pulse_style && global_en && (usb_stat & usb_en) == '0 && (dma_stat & dma_en) == '0)
      |=> !pin_on;
   endproperty
   a_unmasked_only: assert property (p_unmasked_only) else $error("disabled bit drove pin");

   sequence s_pulse_shape;
      ##1 pin_on ##1 !pin_on;
   endsequence

   property p_pulse;
      @(posedge clk) disable iff (!rst_n)
      (pulse_style && req_gated && !req_prev && $stable(icfg)) |=> s_pulse_shape;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse shape wrong");

   property p_mode_fields;
      @(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == udi_pkg::OFS_ICFG)
      |=> (control_pipe_irq_mode == $past(reg_wdata[udi_pkg::CTRL_MODE_LSB +: 2])
           && in_pipe_irq_mode == $past(reg_wdata[udi_pkg::IN_MODE_LSB +: 2])
           && out_pipe_irq_mode == $past(reg_wdata[udi_pkg::OUT_MODE_LSB +: 2]));
   endproperty
   a_mode_fields: assert property (p_mode_fields) else $error("pipe mode not stored");

   property p_polarity;
      @(posedge clk) disable iff (!rst_n)
      (!pulse_style && next_irq_active && $stable(icfg)) |=> (irq_pin == $past(pol_high));
   endproperty
   a_polarity: assert property (p_polarity) else $error("polarity wrong");

   property p_global_gate;
      @(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == udi_pkg::OFS_MODE && !reg_wdata[udi_pkg::GLINT_BIT] && !irq_active)
      ##1 (!pulse_style) |=> !pin_on;
   endproperty
   a_global_gate: assert property (p_global_gate) else $error("global mask failed");

   property p_combine;
      @(posedge clk) disable iff (!rst_n)
      (!pulse_style && pol_high && global_en && $stable(icfg)) |=> (irq_pin == $past(req_any));
   endproperty
   a_combine: assert property (p_combine) else $error("request combine wrong");

endmodule

/* File: verification/udi_mcu_model.sv */
`timescale 1ns/10ps
// Far-side processor: counts interrupt assertions seen at its input pin
module udi_mcu_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic irq_pin,
   input wire logic pol_high,
   output logic [7:0] n_edges,
   output logic [7:0] n_active
);
   logic was_active;
   logic active;
   // Polarity follows what software last programmed
   assign active = (irq_pin == pol_high);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         was_active <= 1'h0;
         n_edges <= 8'h00;
         n_active <= 8'h00;
      end else begin
         was_active <= active;
         if (active && !was_active) begin
            n_edges <= n_edges + 8'h01;
         end
         if (active) begin
            n_active <= n_active + 8'h01;
         end
      end
   end
endmodule

/* File: verification/test_usb_device_irq_output.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
   begin \
      num_checks++; \
      if ((got) !== (ex)) begin \
         n_mismatch++; \
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
      end \
   end
module test_usb_device_irq_output;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic [31:0] reg_rdata;
   logic [31:0] usb_event = 32'h0000_0000;
   logic [15:0] dma_event = 16'h0000;
   logic irq_pin;
   logic [1:0] cmode;
   logic [1:0] imode;
   logic [1:0] omode;
   logic pol_high = 1'h0;
   logic [7:0] n_edges;
   logic [7:0] n_active;
   logic [7:0] e0;
   logic [7:0] a0;
   int num_checks = 0;
   int n_mismatch = 0;

   always #50 clk = ~clk;

   udi_irq udi_irq_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .usb_event(usb_event),
      .dma_event(dma_event), .irq_pin(irq_pin), .control_pipe_irq_mode(cmode),
      .in_pipe_irq_mode(imode), .out_pipe_irq_mode(omode));
   udi_mcu_model udi_mcu_model_i (.clk(clk), .rst_n(rst_n), .irq_pin(irq_pin),
      .pol_high(pol_high), .n_edges(n_edges), .n_active(n_active));

   // Whole 32-bit word, so every byte lane of a clear register is written
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex, input string nm);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1;
      `CHK(nm, ex, reg_rdata)
   endtask

   task automatic pin_chk(input int n, input logic ex, input string nm);
      repeat (n) @(posedge clk);
      #1;
      `CHK(nm, ex, irq_pin)
   endtask

   task automatic ev(input logic [31:0] u, input logic [15:0] d);
      @(posedge clk);
      usb_event <= u;
      dma_event <= d;
      @(posedge clk);
      usb_event <= 32'h0000_0000;
      dma_event <= 16'h0000;
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Tests need about 150 cycles; generous margin
   initial begin
      repeat (3000) @(posedge clk);
      n_mismatch++;
      give_verdict();
   end

   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'h1;
      pin_chk(1, 1'h1, "pin idle");
      rd_chk(udi_pkg::OFS_MODE, 32'h0000_0000, "mode");
      rd_chk(udi_pkg::OFS_ICFG, 32'h0000_0000, "icfg");
      rd_chk(udi_pkg::OFS_USB_EN, 32'h0000_0000, "usb en");
      $display("test reset done");

      wr(udi_pkg::OFS_ICFG, 32'hFFFF_FFE4);
      rd_chk(udi_pkg::OFS_ICFG, 32'h0000_00E4, "icfg rw");
      `CHK("ctrl mode", 2'h1, cmode)
      `CHK("in mode", 2'h2, imode)
      `CHK("out mode", 2'h3, omode)
      rd_chk(8'h30, 32'h0000_0000, "unmapped");
      rd_chk(udi_pkg::OFS_USB_CLR, 32'h0000_0000, "clear reg");
      wr(udi_pkg::OFS_ICFG, 32'h0000_0000);
      // Global enable stays off; upper half must not stick
      wr(udi_pkg::OFS_MODE, 32'hFFFF_FFF7);
      rd_chk(udi_pkg::OFS_MODE, 32'h0000_FFF7, "mode rw");
      wr(udi_pkg::OFS_MODE, 32'h0000_0000);
      pin_chk(2, 1'h1, "gate off idle");
      $display("test registers done");

      wr(udi_pkg::OFS_USB_EN, 32'h0000_0021);
      rd_chk(udi_pkg::OFS_USB_EN, 32'h0000_0021, "usb en rw");
      ev(32'h0000_0020, 16'h0000);
      rd_chk(udi_pkg::OFS_USB_STAT, 32'h0000_0020, "usb stat");
      pin_chk(3, 1'h1, "masked pin");
      wr(udi_pkg::OFS_MODE, 32'h0000_0008);
      pin_chk(2, 1'h0, "global on");
      wr(udi_pkg::OFS_MODE, 32'h0000_0000);
      pin_chk(3, 1'h0, "global off");
      wr(udi_pkg::OFS_USB_CLR, 32'h0000_0000);
      rd_chk(udi_pkg::OFS_USB_STAT, 32'h0000_0020, "zero clear");
      wr(udi_pkg::OFS_USB_CLR, 32'h0000_0020);
      pin_chk(2, 1'h1, "released");
      rd_chk(udi_pkg::OFS_USB_STAT, 32'h0000_0000, "one clear");
      $display("test global enable done");

      wr(udi_pkg::OFS_MODE, 32'h0000_0008);
      ev(32'h0000_0000, 16'h0004);
      rd_chk(udi_pkg::OFS_DMA_STAT, 32'h0000_0004, "dma stat");
      pin_chk(3, 1'h1, "dma masked");
      wr(udi_pkg::OFS_DMA_EN, 32'h0000_0004);
      rd_chk(udi_pkg::OFS_DMA_EN, 32'h0000_0004, "dma en rw");
      `CHK("dma enabled", 1'h0, irq_pin)
      wr(udi_pkg::OFS_DMA_CLR, 32'h0000_0004);
      pin_chk(2, 1'h1, "dma released");
      $display("test dma done");

      wr(udi_pkg::OFS_ICFG, 32'h0000_0002);
      pol_high <= 1'h1;
      pin_chk(2, 1'h0, "high idle");
      ev(32'h0000_0020, 16'h0000);
      pin_chk(3, 1'h1, "high active");
      wr(udi_pkg::OFS_USB_CLR, 32'h0000_0020);
      pin_chk(2, 1'h0, "high released");
      $display("test polarity done");

      wr(udi_pkg::OFS_ICFG, 32'h0000_0001);
      pol_high <= 1'h0;
      pin_chk(2, 1'h1, "pulse idle");
      e0 = n_edges;
      a0 = n_active;
      ev(32'h0000_0020, 16'h0000);
      repeat (8) @(posedge clk);
      #1;
      `CHK("pulse count", e0 + 8'h01, n_edges)
      `CHK("pulse width", a0 + udi_pkg::PULSE_CYC, n_active)
      ev(32'h0000_0001, 16'h0000);
      repeat (8) @(posedge clk);
      #1;
      `CHK("no repulse", e0 + 8'h01, n_edges)
      wr(udi_pkg::OFS_USB_CLR, 32'h0000_0021);
      ev(32'h0000_0001, 16'h0000);
      repeat (8) @(posedge clk);
      #1;
      `CHK("second pulse", e0 + 8'h02, n_edges)
      // Pulse style must obey the global mask too
      wr(udi_pkg::OFS_USB_CLR, 32'h0000_0021);
      wr(udi_pkg::OFS_MODE, 32'h0000_0000);
      ev(32'h0000_0001, 16'h0000);
      repeat (8) @(posedge clk);
      #1;
      `CHK("masked pulse", e0 + 8'h02, n_edges)
      rd_chk(udi_pkg::OFS_USB_STAT, 32'h0000_0001, "masked logged");
      $display("test pulse done");

      // Reset in mid-run must restore level style, active low
      @(posedge clk);
      rst_n <= 1'h0;
      repeat (3) @(posedge clk);
      rst_n <= 1'h1;
      pin_chk(1, 1'h1, "pin after reset");
      rd_chk(udi_pkg::OFS_ICFG, 32'h0000_0000, "icfg after reset");
      rd_chk(udi_pkg::OFS_USB_STAT, 32'h0000_0000, "stat after reset");
      $display("test mid reset done");
      give_verdict();
   end
endmodule
